/* event_latch_pkg.sv */
package event_latch_pkg;

   // Printed register indices; the byte address is four times the index
   localparam logic [15:0] IDX_CHG_STATUS = 16'h4012;
   localparam logic [15:0] IDX_LDO_STATUS = 16'h4013;
   localparam logic [15:0] IDX_CONV_STATUS = 16'h4014;
   localparam logic [15:0] IDX_PIN_CONFIG = 16'h4017;
   localparam logic [15:0] IDX_CHG_MASK = 16'h401a;
   localparam logic [15:0] IDX_LDO_MASK = 16'h401b;
   localparam logic [15:0] IDX_CONV_MASK = 16'h401c;

   // Register slots inside the block
   localparam logic [2:0] SLOT_CHG = 3'h0;
   localparam logic [2:0] SLOT_LDO = 3'h1;
   localparam logic [2:0] SLOT_CONV = 3'h2;
   localparam logic [2:0] SLOT_MASK0 = 3'h3;
   localparam logic [2:0] SLOT_PIN = 3'h6;
   localparam logic [2:0] SLOT_NONE = 3'h7;
   localparam int NUM_STATUS = 3;

   // Implemented flag bits of each status register
   localparam logic [15:0] CHG_VALID = 16'h07f7;
   localparam logic [15:0] LDO_VALID = 16'h005f;
   localparam logic [15:0] CONV_VALID = 16'h030f;

   // Flag positions, charger and system register
   localparam int BIT_CHG_TIMEOUT = 10;
   localparam int BIT_CHG_MODE = 9;
   localparam int BIT_CHG_START = 8;
   localparam int BIT_SINK_TWO = 7;
   localparam int BIT_SINK_ONE = 6;
   localparam int BIT_NVM_DONE = 5;
   localparam int BIT_NVM_FAIL = 4;
   localparam int BIT_POR = 2;
   localparam int BIT_SLEEP_OFF = 1;
   localparam int BIT_ON_WAKE = 0;
   // Regulator undervoltage register
   localparam int BIT_REG7_UV = 6;
   localparam int BIT_REG5_UV = 4;
   localparam int BIT_REG4_UV = 3;
   localparam int BIT_REG3_UV = 2;
   localparam int BIT_REG2_UV = 1;
   localparam int BIT_REG1_UV = 0;
   // Converter fault register
   localparam int BIT_CONV2_HC = 9;
   localparam int BIT_CONV1_HC = 8;
   localparam int BIT_CONV4_UV = 3;
   localparam int BIT_CONV3_UV = 2;
   localparam int BIT_CONV2_UV = 1;
   localparam int BIT_CONV1_UV = 0;
   // Pin configuration register
   localparam int BIT_PIN_MASK = 0;

   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic PIN_MASK_RESET = 1'b0;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : event_latch_pkg

/* pmic_event_status_latches.sv */
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// R1: Charger timer expiry edge sets bit 10
// R2: Charger mode change edge sets bit 9
// R3: Charging start edge sets bit 8
// R4: Sink two edge bit 7, sink one bit 6
// R5: Memory command end edge sets bit 5
// R6: Memory command fail edge sets bit 4
// R7: Power-on reset edge sets bit 2
// R8: Entry to sleep or off sets bit 1
// R9: Entry to on state sets bit 0
// R10: Regulator undervoltage edges set third register bits
// R11: Converter current and undervoltage edges set fourth register
// R12: Writing one clears flag, zero keeps it
// R13: All flags are zero after reset
// R14: Pin output mask blocks the interrupt request
// R15: Each latched flag is its own output
module pmic_event_status_latches #(
   parameter int ADDR_W = 20,
   parameter logic [15:0] MASK_RESET = 16'hffff
) (
   input wire logic clk,
   input wire logic sys_rst,
   // AXI4-Lite slave
   input wire logic awvalid,
   output logic awready,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Event sources
   input wire logic charger_timeout_event,
   input wire logic charge_mode_change_event,
   input wire logic charging_started_event,
   input wire logic sink_two_event,
   input wire logic sink_one_event,
   input wire logic nvm_command_done_event,
   input wire logic nvm_command_fail_event,
   input wire logic power_on_reset_event,
   input wire logic sleep_or_off_event,
   input wire logic on_or_wake_event,
   input wire logic regulator7_undervoltage_event,
   input wire logic regulator5_undervoltage_event,
   input wire logic regulator4_undervoltage_event,
   input wire logic regulator3_undervoltage_event,
   input wire logic regulator2_undervoltage_event,
   input wire logic regulator1_undervoltage_event,
   input wire logic converter2_high_current_event,
   input wire logic converter1_high_current_event,
   input wire logic converter4_undervoltage_event,
   input wire logic converter3_undervoltage_event,
   input wire logic converter2_undervoltage_event,
   input wire logic converter1_undervoltage_event,
   // Latched flags
   output logic charger_timeout_flag,
   output logic charge_mode_change_flag,
   output logic charging_started_flag,
   output logic sink_two_flag,
   output logic sink_one_flag,
   output logic nvm_command_done_flag,
   output logic nvm_command_fail_flag,
   output logic power_on_reset_flag,
   output logic sleep_or_off_flag,
   output logic on_or_wake_flag,
   output logic regulator7_undervoltage_flag,
   output logic regulator5_undervoltage_flag,
   output logic regulator4_undervoltage_flag,
   output logic regulator3_undervoltage_flag,
   output logic regulator2_undervoltage_flag,
   output logic regulator1_undervoltage_flag,
   output logic converter2_high_current_flag,
   output logic converter1_high_current_flag,
   output logic converter4_undervoltage_flag,
   output logic converter3_undervoltage_flag,
   output logic converter2_undervoltage_flag,
   output logic converter1_undervoltage_flag,
   output logic irq
);

   typedef logic [event_latch_pkg::NUM_STATUS-1:0][15:0] bank_t;

   typedef struct packed {
      bank_t sync1;
      bank_t sync2;
      bank_t prev;
      bank_t status;
      bank_t mask;
      logic pin_mask;
      logic aw_got;
      logic [ADDR_W-1:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } state_t;

   state_t state_reg;
   state_t state_next;
   bank_t events;
   bank_t rise;
   bank_t clear;
   bank_t valid;
   logic write_fire;
   logic [2:0] wslot;
   logic [2:0] rslot;
   logic [15:0] byte_en;
   logic [15:0] wval;

   // Maps a byte address to a register slot
   function automatic logic [2:0] reg_slot(input logic [ADDR_W-1:0] addr);
      logic [ADDR_W-3:0] idx;
      idx = addr[ADDR_W-1:2];
      if (addr[1:0] != 2'h0) begin
         reg_slot = event_latch_pkg::SLOT_NONE;
      end else if (idx == (ADDR_W-2)'(event_latch_pkg::IDX_CHG_STATUS)) begin
         reg_slot = event_latch_pkg::SLOT_CHG;
      end else if (idx == (ADDR_W-2)'(event_latch_pkg::IDX_LDO_STATUS)) begin
         reg_slot = event_latch_pkg::SLOT_LDO;
      end else if (idx == (ADDR_W-2)'(event_latch_pkg::IDX_CONV_STATUS)) begin
         reg_slot = event_latch_pkg::SLOT_CONV;
      end else if (idx == (ADDR_W-2)'(event_latch_pkg::IDX_CHG_MASK)) begin
         reg_slot = event_latch_pkg::SLOT_MASK0;
      end else if (idx == (ADDR_W-2)'(event_latch_pkg::IDX_LDO_MASK)) begin
         reg_slot = event_latch_pkg::SLOT_MASK0 + 3'h1;
      end else if (idx == (ADDR_W-2)'(event_latch_pkg::IDX_CONV_MASK)) begin
         reg_slot = event_latch_pkg::SLOT_MASK0 + 3'h2;
      end else if (idx == (ADDR_W-2)'(event_latch_pkg::IDX_PIN_CONFIG)) begin
         reg_slot = event_latch_pkg::SLOT_PIN;
      end else begin
         reg_slot = event_latch_pkg::SLOT_NONE;
      end
   endfunction : reg_slot

   assign valid[0] = event_latch_pkg::CHG_VALID;
   assign valid[1] = event_latch_pkg::LDO_VALID;
   assign valid[2] = event_latch_pkg::CONV_VALID;

   // Gather event sources into register layout
   always_comb begin
      events = '0;
      events[0][event_latch_pkg::BIT_CHG_TIMEOUT] = charger_timeout_event;
      events[0][event_latch_pkg::BIT_CHG_MODE] = charge_mode_change_event;
      events[0][event_latch_pkg::BIT_CHG_START] = charging_started_event;
      events[0][event_latch_pkg::BIT_SINK_TWO] = sink_two_event;
      events[0][event_latch_pkg::BIT_SINK_ONE] = sink_one_event;
      events[0][event_latch_pkg::BIT_NVM_DONE] = nvm_command_done_event;
      events[0][event_latch_pkg::BIT_NVM_FAIL] = nvm_command_fail_event;
      events[0][event_latch_pkg::BIT_POR] = power_on_reset_event;
      events[0][event_latch_pkg::BIT_SLEEP_OFF] = sleep_or_off_event;
      events[0][event_latch_pkg::BIT_ON_WAKE] = on_or_wake_event;
      events[1][event_latch_pkg::BIT_REG7_UV] = regulator7_undervoltage_event;
      events[1][event_latch_pkg::BIT_REG5_UV] = regulator5_undervoltage_event;
      events[1][event_latch_pkg::BIT_REG4_UV] = regulator4_undervoltage_event;
      events[1][event_latch_pkg::BIT_REG3_UV] = regulator3_undervoltage_event;
      events[1][event_latch_pkg::BIT_REG2_UV] = regulator2_undervoltage_event;
      events[1][event_latch_pkg::BIT_REG1_UV] = regulator1_undervoltage_event;
      events[2][event_latch_pkg::BIT_CONV2_HC] = converter2_high_current_event;
      events[2][event_latch_pkg::BIT_CONV1_HC] = converter1_high_current_event;
      events[2][event_latch_pkg::BIT_CONV4_UV] = converter4_undervoltage_event;
      events[2][event_latch_pkg::BIT_CONV3_UV] = converter3_undervoltage_event;
      events[2][event_latch_pkg::BIT_CONV2_UV] = converter2_undervoltage_event;
      events[2][event_latch_pkg::BIT_CONV1_UV] = converter1_undervoltage_event;
   end

   assign write_fire = state_reg.aw_got && state_reg.w_got && !state_reg.bvalid;
   assign wslot = reg_slot(state_reg.aw_addr);
   assign rslot = reg_slot(araddr);
   assign byte_en = {{8{state_reg.w_strb[1]}}, {8{state_reg.w_strb[0]}}};
   assign wval = state_reg.w_data[15:0] & byte_en;

   always_comb begin
      state_next = state_reg;
      // Event inputs come from other domains: two flops, then edge detect
      state_next.sync1 = events;
      state_next.sync2 = state_reg.sync1;
      state_next.prev = state_reg.sync2;
      for (int i = 0; i < event_latch_pkg::NUM_STATUS; i++) begin
         rise[i] = state_reg.sync2[i] & ~state_reg.prev[i] & valid[i]; // R1 R2 R3 R4 R5 R6 R7 R8 R9 R10 R11
         clear[i] = (write_fire && wslot == 3'(i)) ? wval : 16'h0000; // R12
         // A new edge in the clearing cycle survives the clear
         state_next.status[i] = ((state_reg.status[i] & ~clear[i]) | rise[i]) & valid[i]; // R12
         if (write_fire && wslot == 3'(i) + event_latch_pkg::SLOT_MASK0) begin
            state_next.mask[i] = ((state_reg.mask[i] & ~byte_en) | wval) & valid[i];
         end
      end
      if (write_fire && wslot == event_latch_pkg::SLOT_PIN && state_reg.w_strb[0]) begin
         state_next.pin_mask = state_reg.w_data[event_latch_pkg::BIT_PIN_MASK];
      end
      // Write channel: address and data may arrive in either order
      if (awvalid && awready) begin
         state_next.aw_got = 1'b1;
         state_next.aw_addr = awaddr;
      end
      if (wvalid && wready) begin
         state_next.w_got = 1'b1;
         state_next.w_data = wdata;
         state_next.w_strb = wstrb;
      end
      if (write_fire) begin
         state_next.aw_got = 1'b0;
         state_next.w_got = 1'b0;
         state_next.bvalid = 1'b1;
         state_next.bresp = (wslot == event_latch_pkg::SLOT_NONE) ?
            event_latch_pkg::RESP_SLVERR : event_latch_pkg::RESP_OKAY;
      end else if (state_reg.bvalid && bready) begin
         state_next.bvalid = 1'b0;
      end
      // Read channel
      if (arvalid && arready) begin
         state_next.rvalid = 1'b1;
         state_next.rresp = event_latch_pkg::RESP_OKAY;
         state_next.rdata = 32'h0000_0000;
         if (rslot < event_latch_pkg::SLOT_MASK0) begin
            state_next.rdata[15:0] = state_reg.status[rslot[1:0]];
         end else if (rslot < event_latch_pkg::SLOT_PIN) begin
            state_next.rdata[15:0] = state_reg.mask[2'(rslot - event_latch_pkg::SLOT_MASK0)];
         end else if (rslot == event_latch_pkg::SLOT_PIN) begin
            state_next.rdata[event_latch_pkg::BIT_PIN_MASK] = state_reg.pin_mask;
         end else begin
            state_next.rresp = event_latch_pkg::RESP_SLVERR;
         end
      end else if (state_reg.rvalid && rready) begin
         state_next.rvalid = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= '0;
         state_reg.status <= {event_latch_pkg::NUM_STATUS{event_latch_pkg::STATUS_RESET}}; // R13
         state_reg.mask <= {MASK_RESET & event_latch_pkg::CONV_VALID,
                            MASK_RESET & event_latch_pkg::LDO_VALID,
                            MASK_RESET & event_latch_pkg::CHG_VALID};
         state_reg.pin_mask <= event_latch_pkg::PIN_MASK_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   assign awready = !state_reg.aw_got && !state_reg.bvalid;
   assign wready = !state_reg.w_got && !state_reg.bvalid;
   assign bvalid = state_reg.bvalid;
   assign bresp = state_reg.bresp;
   assign arready = !state_reg.rvalid;
   assign rvalid = state_reg.rvalid;
   assign rdata = state_reg.rdata;
   assign rresp = state_reg.rresp;

   // Pending unmasked flag drives the request unless the pin is masked
   assign irq = !state_reg.pin_mask && |(state_reg.status & ~state_reg.mask); // R14

   // Each flag leaves the block on its own port
   assign charger_timeout_flag = state_reg.status[0][event_latch_pkg::BIT_CHG_TIMEOUT]; // R15
   assign charge_mode_change_flag = state_reg.status[0][event_latch_pkg::BIT_CHG_MODE];
   assign charging_started_flag = state_reg.status[0][event_latch_pkg::BIT_CHG_START];
   assign sink_two_flag = state_reg.status[0][event_latch_pkg::BIT_SINK_TWO];
   assign sink_one_flag = state_reg.status[0][event_latch_pkg::BIT_SINK_ONE];
   assign nvm_command_done_flag = state_reg.status[0][event_latch_pkg::BIT_NVM_DONE];
   assign nvm_command_fail_flag = state_reg.status[0][event_latch_pkg::BIT_NVM_FAIL];
   assign power_on_reset_flag = state_reg.status[0][event_latch_pkg::BIT_POR];
   assign sleep_or_off_flag = state_reg.status[0][event_latch_pkg::BIT_SLEEP_OFF];
   assign on_or_wake_flag = state_reg.status[0][event_latch_pkg::BIT_ON_WAKE];
   assign regulator7_undervoltage_flag = state_reg.status[1][event_latch_pkg::BIT_REG7_UV];
   assign regulator5_undervoltage_flag = state_reg.status[1][event_latch_pkg::BIT_REG5_UV];
   assign regulator4_undervoltage_flag = state_reg.status[1][event_latch_pkg::BIT_REG4_UV];
   assign regulator3_undervoltage_flag = state_reg.status[1][event_latch_pkg::BIT_REG3_UV];
   assign regulator2_undervoltage_flag = state_reg.status[1][event_latch_pkg::BIT_REG2_UV];
   assign regulator1_undervoltage_flag = state_reg.status[1][event_latch_pkg::BIT_REG1_UV];
   assign converter2_high_current_flag = state_reg.status[2][event_latch_pkg::BIT_CONV2_HC];
   assign converter1_high_current_flag = state_reg.status[2][event_latch_pkg::BIT_CONV1_HC];
   assign converter4_undervoltage_flag = state_reg.status[2][event_latch_pkg::BIT_CONV4_UV];
   assign converter3_undervoltage_flag = state_reg.status[2][event_latch_pkg::BIT_CONV3_UV];
   assign converter2_undervoltage_flag = state_reg.status[2][event_latch_pkg::BIT_CONV2_UV];
   assign converter1_undervoltage_flag = state_reg.status[2][event_latch_pkg::BIT_CONV1_UV];

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Input edge reaches the flag three edges later
   sequence s_edge(sig);
      !sig ##1 sig;
   endsequence
   property p_timeout;
      s_edge(charger_timeout_event) |-> ##3 charger_timeout_flag;
   endproperty
   a_timeout: assert property (p_timeout) else $error("timeout flag not set"); // R1
   property p_mode;
      s_edge(charge_mode_change_event) |-> ##3 charge_mode_change_flag;
   endproperty
   a_mode: assert property (p_mode) else $error("mode flag not set"); // R2
   property p_start;
      $rose(charging_started_event) |-> ##3 charging_started_flag;
   endproperty
   a_start: assert property (p_start) else $error("start flag not set"); // R3
   property p_sinks;
      (rise[0][event_latch_pkg::BIT_SINK_TWO] |=> sink_two_flag) and
      (rise[0][event_latch_pkg::BIT_SINK_ONE] |=> sink_one_flag);
   endproperty
   a_sinks: assert property (p_sinks) else $error("sink flag not set"); // R4
   property p_nvm_done;
      $rose(nvm_command_done_event) |-> ##3 nvm_command_done_flag;
   endproperty
   a_nvm_done: assert property (p_nvm_done) else $error("nvm done flag not set"); // R5
   property p_nvm_fail;
      $rose(nvm_command_fail_event) |-> ##3 nvm_command_fail_flag;
   endproperty
   a_nvm_fail: assert property (p_nvm_fail) else $error("nvm fail flag not set"); // R6
   property p_por;
      $rose(power_on_reset_event) |-> ##3 power_on_reset_flag;
   endproperty
   a_por: assert property (p_por) else $error("reset flag not set"); // R7
   property p_sleep;
      $rose(sleep_or_off_event) |-> ##3 sleep_or_off_flag;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep flag not set"); // R8
   property p_wake;
      $rose(on_or_wake_event) |-> ##3 on_or_wake_flag;
   endproperty
   a_wake: assert property (p_wake) else $error("wake flag not set"); // R9
   property p_ldo;
      (rise[1] != 16'h0000) |=> ((state_reg.status[1] & $past(rise[1])) == $past(rise[1]));
   endproperty
   a_ldo: assert property (p_ldo) else $error("regulator flag not set"); // R10
   property p_conv;
      (rise[2] != 16'h0000) |=> ((state_reg.status[2] & $past(rise[2])) == $past(rise[2]));
   endproperty
   a_conv: assert property (p_conv) else $error("converter flag not set"); // R11
   property p_clear;
      (write_fire && wslot == event_latch_pkg::SLOT_CHG && rise[0] == 16'h0000) |=>
         ((state_reg.status[0] & $past(wval)) == 16'h0000) && bvalid;
   endproperty
   a_clear: assert property (p_clear) else $error("flag not cleared by one"); // R12
   property p_keep;
      (state_reg.status[0] != 16'h0000 && !write_fire) |=>
         ((state_reg.status[0] & $past(state_reg.status[0])) == $past(state_reg.status[0]));
   endproperty
   a_keep: assert property (p_keep) else $error("flag lost without clear"); // R12
   property p_reserved;
      (state_reg.status[0] & ~event_latch_pkg::CHG_VALID) == 16'h0000 &&
      (state_reg.status[1] & ~event_latch_pkg::LDO_VALID) == 16'h0000 &&
      (state_reg.status[2] & ~event_latch_pkg::CONV_VALID) == 16'h0000;
   endproperty
   a_reserved: assert property (p_reserved) else $error("unused status bit set"); // R13
   property p_pin_mask;
      state_reg.pin_mask |-> !irq;
   endproperty
   a_pin_mask: assert property (p_pin_mask) else $error("request not suppressed"); // R14
endmodule : pmic_event_status_latches

`default_nettype wire

/* event_source_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Far side event sources: raises the requested lines for len cycles, then returns them low
module event_source_model (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic go,
   input wire logic [47:0] pattern,
   input wire logic [7:0] len,
   output logic [47:0] ev
);
   logic [7:0] left_reg;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ev <= 48'h0;
         left_reg <= 8'h0;
      end else if (go) begin
         ev <= pattern;
         left_reg <= len;
      end else if (left_reg > 8'h1) begin
         left_reg <= left_reg - 8'h1;
      end else begin
         ev <= 48'h0;
         left_reg <= 8'h0;
      end
   end
endmodule : event_source_model
`default_nettype wire

/* pmic_event_status_latches_test.sv */
`timescale 1ns/1ps
`default_nettype none
module pmic_event_status_latches_test;
   localparam logic [47:0] VALID = {event_latch_pkg::CONV_VALID, event_latch_pkg::LDO_VALID,
      event_latch_pkg::CHG_VALID};
   localparam logic [1:0] OK = event_latch_pkg::RESP_OKAY;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, go = 1'b0;
   logic [19:0] awaddr = 20'h0, araddr = 20'h0;
   logic [31:0] wdata = 32'h0, c;
   logic [47:0] pattern = 48'h0, exp_fl = 48'h0, p;
   logic [7:0] len = 8'h1;
   wire logic awready, wready, bvalid, arready, rvalid, irq;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [47:0] ev, fl;
   logic [1:0] exp_b[$];
   logic [33:0] exp_r[$];
   int n_errors = 0, samples_checked = 0, cycles = 0, seed = 81;
   always #10 clk = ~clk;
   event_source_model i_src (.clk, .sys_rst, .go, .pattern, .len, .ev);
   pmic_event_status_latches i_dut (.clk, .sys_rst, .awvalid, .awready, .awaddr, .awprot(3'h0),
      .wvalid, .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready,
      .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .irq,
      .charger_timeout_event(ev[10]), .charge_mode_change_event(ev[9]),
      .charging_started_event(ev[8]), .sink_two_event(ev[7]), .sink_one_event(ev[6]),
      .nvm_command_done_event(ev[5]), .nvm_command_fail_event(ev[4]),
      .power_on_reset_event(ev[2]), .sleep_or_off_event(ev[1]), .on_or_wake_event(ev[0]),
      .regulator7_undervoltage_event(ev[22]), .regulator5_undervoltage_event(ev[20]),
      .regulator4_undervoltage_event(ev[19]), .regulator3_undervoltage_event(ev[18]),
      .regulator2_undervoltage_event(ev[17]), .regulator1_undervoltage_event(ev[16]),
      .converter2_high_current_event(ev[41]), .converter1_high_current_event(ev[40]),
      .converter4_undervoltage_event(ev[35]), .converter3_undervoltage_event(ev[34]),
      .converter2_undervoltage_event(ev[33]), .converter1_undervoltage_event(ev[32]),
      .charger_timeout_flag(fl[10]), .charge_mode_change_flag(fl[9]),
      .charging_started_flag(fl[8]), .sink_two_flag(fl[7]), .sink_one_flag(fl[6]),
      .nvm_command_done_flag(fl[5]), .nvm_command_fail_flag(fl[4]),
      .power_on_reset_flag(fl[2]), .sleep_or_off_flag(fl[1]), .on_or_wake_flag(fl[0]),
      .regulator7_undervoltage_flag(fl[22]), .regulator5_undervoltage_flag(fl[20]),
      .regulator4_undervoltage_flag(fl[19]), .regulator3_undervoltage_flag(fl[18]),
      .regulator2_undervoltage_flag(fl[17]), .regulator1_undervoltage_flag(fl[16]),
      .converter2_high_current_flag(fl[41]), .converter1_high_current_flag(fl[40]),
      .converter4_undervoltage_flag(fl[35]), .converter3_undervoltage_flag(fl[34]),
      .converter2_undervoltage_flag(fl[33]), .converter1_undervoltage_flag(fl[32]));

   function automatic logic [15:0] sidx(input int r);
      return event_latch_pkg::IDX_CHG_STATUS + 16'(r);
   endfunction : sidx

   function automatic logic [31:0] slice(input logic [47:0] v, input int r);
      return {16'h0, v[16 * r +: 16]};
   endfunction : slice

   task automatic conclude();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : conclude

   task automatic cmp_bus(input logic [33:0] got, input logic [33:0] want);
      samples_checked++;
      if (got !== want) begin
         n_errors++;
         $display("ERROR at %0t: bus got %h want %h", $time, got, want);
      end
   endtask : cmp_bus

   task automatic chk(input logic [48:0] want);
      samples_checked++;
      if ({irq, fl & VALID} !== want) begin
         n_errors++;
         $display("ERROR at %0t: flags got %h want %h", $time, {irq, fl & VALID}, want);
      end
   endtask : chk

   task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] r);
      @(posedge clk);
      exp_b.push_back(r);
      awaddr <= {2'b00, idx, 2'b00};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] r);
      @(posedge clk);
      exp_r.push_back({r, d});
      araddr <= {2'b00, idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
   endtask : rd

   task automatic fire(input logic [47:0] v, input logic [7:0] n);
      @(posedge clk);
      pattern <= v;
      len <= n;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      exp_fl = exp_fl | v;
      repeat (5) @(posedge clk);
   endtask : fire

   always @(posedge clk) begin
      cycles++;
      if (rvalid === 1'b1 && rready) cmp_bus({rresp, rdata}, exp_r.pop_front());
      if (bvalid === 1'b1 && bready) cmp_bus({32'h0, bresp}, {32'h0, exp_b.pop_front()});
      if (cycles == 10000) begin
         n_errors++;
         $display("ERROR at %0t: timeout", $time);
         conclude();
      end
   end

   initial begin
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      for (int r = 0; r < 3; r++) rd(sidx(r), 32'h0, OK);
      rd(event_latch_pkg::IDX_PIN_CONFIG, 32'h0, OK);
      rd(event_latch_pkg::IDX_CONV_MASK, {16'h0, event_latch_pkg::CONV_VALID}, OK);
      chk(49'h0);
      $display("test reset done");
      for (int i = 0; i < 48; i++) begin
         if (VALID[i]) begin
            p = 48'h1 << i;
            fire(p, 8'(1 + {$random(seed)} % 4));
            chk({1'b0, exp_fl});
            rd(sidx(i / 16), slice(p, i / 16), OK);
            wr(sidx(i / 16), 32'h0, OK);
            chk({1'b0, exp_fl});
            wr(sidx(i / 16), slice(p, i / 16), OK);
            exp_fl = 48'h0;
            chk(49'h0);
         end
      end
      $display("test single flags done");
      repeat (3) begin
         p = 48'({$random(seed), $random(seed)}) & VALID;
         fire(p, 8'h14);
         chk({1'b0, exp_fl});
         for (int r = 0; r < 3; r++) begin
            c = $random(seed);
            wr(sidx(r), c, OK);
            exp_fl[16 * r +: 16] = exp_fl[16 * r +: 16] & ~c[15:0];
         end
         // Sources are still high here, so nothing may latch again
         chk({1'b0, exp_fl});
         for (int r = 0; r < 3; r++) rd(sidx(r), slice(exp_fl, r), OK);
         repeat (10) @(posedge clk);
         for (int r = 0; r < 3; r++) wr(sidx(r), 32'hffff, OK);
         exp_fl = 48'h0;
         chk(49'h0);
      end
      $display("test random flags done");
      wr(event_latch_pkg::IDX_CHG_MASK, 32'hffff, OK);
      rd(event_latch_pkg::IDX_CHG_MASK, {16'h0, event_latch_pkg::CHG_VALID}, OK);
      fire(48'h1, 8'h1);
      chk({1'b0, exp_fl});
      wr(event_latch_pkg::IDX_CHG_MASK, 32'h0, OK);
      chk({1'b1, exp_fl});
      wr(event_latch_pkg::IDX_PIN_CONFIG, 32'h1, OK);
      rd(event_latch_pkg::IDX_PIN_CONFIG, 32'h1, OK);
      chk({1'b0, exp_fl});
      wr(event_latch_pkg::IDX_PIN_CONFIG, 32'h0, OK);
      chk({1'b1, exp_fl});
      wr(sidx(0), 32'h1, OK);
      exp_fl = 48'h0;
      chk(49'h0);
      wr(16'h4015, 32'hffff, event_latch_pkg::RESP_SLVERR);
      rd(16'h4015, 32'h0, event_latch_pkg::RESP_SLVERR);
      $display("test interrupt and unmapped done");
      fire(VALID, 8'h2);
      chk({1'b1, exp_fl});
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      exp_fl = 48'h0;
      @(posedge clk);
      chk(49'h0);
      rd(sidx(2), 32'h0, OK);
      $display("test mid-run reset done");
      conclude();
   end
endmodule : pmic_event_status_latches_test
`default_nettype wire
